// ### src/pdc_counter_top.sv
// Presettable decade counter with an AXI4-Lite register slave.
`include "pdc_params.svh"
`default_nettype none

module pdc_counter_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clearN,
  input wire logic trickleIn,
  input wire pdc_pkg::pdc_axi_req_t axiReq,
  output var pdc_pkg::pdc_axi_rsp_t axiRsp,
  output var logic [3:0] countBits,
  output var logic terminalCount
);

  import pdc_pkg::*;

  // Next value of a counting decade; anything at or past nine wraps to zero.
  function automatic logic [3:0] incDecade(input logic [3:0] value);
    if (value >= `PDC_COUNT_MAX) begin
      incDecade = `PDC_COUNT_ZERO;
    end else begin
      incDecade = value + `PDC_COUNT_ONE;
    end
  endfunction

  function automatic pdc_ctrl_t wordToCtrl(input logic [31:0] word);
    pdc_ctrl_t ctrl;
    ctrl.loadValue = word[`PDC_CTRL_LOAD_MSB:`PDC_CTRL_LOAD_LSB];
    ctrl.loadEnableN = word[`PDC_CTRL_LDN];
    ctrl.countEnableTrickle = word[`PDC_CTRL_CET];
    ctrl.countEnableParallel = word[`PDC_CTRL_CEP];
    wordToCtrl = ctrl;
  endfunction

  function automatic logic [31:0] ctrlToWord(input pdc_ctrl_t ctrl);
    logic [31:0] word;
    word = `PDC_WORD_ZERO;
    word[`PDC_CTRL_LOAD_MSB:`PDC_CTRL_LOAD_LSB] = ctrl.loadValue;
    word[`PDC_CTRL_LDN] = ctrl.loadEnableN;
    word[`PDC_CTRL_CET] = ctrl.countEnableTrickle;
    word[`PDC_CTRL_CEP] = ctrl.countEnableParallel;
    ctrlToWord = word;
  endfunction

  function automatic logic isMapped(input logic [31:0] addr);
    isMapped = (addr == `PDC_OFS_CTRL) || (addr == `PDC_OFS_STATUS);
  endfunction

  pdc_ctrl_t ctrlReg;
  pdc_ctrl_t ctrlNext;
  logic [3:0] countReg;
  logic [3:0] countNext;
  logic terminalCountReg;
  logic terminalCountNext;
  logic trickleLevel;
  logic trickleLevelNext;
  logic trickleEff;
  logic trickleEffNext;
  logic clearSeen;
  logic clearHitReg;

  logic awFullReg;
  logic awFullNext;
  logic wFullReg;
  logic wFullNext;
  logic arFullReg;
  logic arFullNext;
  logic awreadyReg;
  logic wreadyReg;
  logic arreadyReg;
  logic bvalidReg;
  logic bvalidNext;
  logic rvalidReg;
  logic rvalidNext;
  logic [31:0] awAddrReg;
  logic [31:0] wDataReg;
  logic [3:0] wStrbReg;
  logic [31:0] arAddrReg;
  logic [31:0] rdataReg;
  logic [1:0] brespReg;
  logic [1:0] rrespReg;
  logic [31:0] statusWord;
  logic doWrite;
  logic doRead;

  // The cascade enable pin and the clear pin are filtered before software sees them.
  pdc_pin_filter trickleFilter (
    .core_clk(core_clk),
    .rst(rst),
    .pinIn(trickleIn),
    .level(trickleLevel),
    .levelNext(trickleLevelNext)
  );

  pdc_pin_filter clearFilter (
    .core_clk(core_clk),
    .rst(rst),
    .pinIn(!clearN),
    .level(clearSeen),
    .levelNext()
  );

  assign trickleEff = ctrlReg.countEnableTrickle && trickleLevel;
  assign trickleEffNext = ctrlNext.countEnableTrickle && trickleLevelNext;

  // Load first, then counting, otherwise hold.
  always_comb begin
    if (!ctrlReg.loadEnableN) begin
      countNext = ctrlReg.loadValue;
    end else if (trickleEff && ctrlReg.countEnableParallel) begin
      countNext = incDecade(countReg);
    end else begin
      countNext = countReg;
    end
  end

  assign terminalCountNext = (countNext == `PDC_COUNT_MAX) && trickleEffNext;

  // The clear pin acts without the clock and beats everything else.
  always_ff @(posedge core_clk or negedge clearN) begin
    if (!clearN) begin
      countReg <= `PDC_COUNT_ZERO;
      clearHitReg <= 1'b1;
    end else if (rst) begin
      countReg <= `PDC_COUNT_ZERO;
      clearHitReg <= 1'b0;
    end else begin
      countReg <= countNext;
      clearHitReg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge clearN) begin
    if (!clearN) begin
      terminalCountReg <= 1'b0;
    end else if (rst) begin
      terminalCountReg <= 1'b0;
    end else begin
      terminalCountReg <= terminalCountNext;
    end
  end

  assign countBits = countReg;
  assign terminalCount = terminalCountReg;

  // Handshake bookkeeping of the five channels.
  always_comb begin
    doWrite = awFullReg && wFullReg && !bvalidReg;
    doRead = arFullReg && !rvalidReg;
    awFullNext = (awFullReg && !doWrite) || (axiReq.awvalid && awreadyReg);
    wFullNext = (wFullReg && !doWrite) || (axiReq.wvalid && wreadyReg);
    arFullNext = (arFullReg && !doRead) || (axiReq.arvalid && arreadyReg);
    bvalidNext = doWrite || (bvalidReg && !axiReq.bready);
    rvalidNext = doRead || (rvalidReg && !axiReq.rready);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      awFullReg <= 1'b0;
      awAddrReg <= `PDC_WORD_ZERO;
      awreadyReg <= 1'b0;
    end else begin
      awFullReg <= awFullNext;
      awreadyReg <= !awFullNext && !bvalidNext;
      if (axiReq.awvalid && awreadyReg) begin
        awAddrReg <= axiReq.awaddr;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wFullReg <= 1'b0;
      wDataReg <= `PDC_WORD_ZERO;
      wStrbReg <= 4'h0;
      wreadyReg <= 1'b0;
    end else begin
      wFullReg <= wFullNext;
      wreadyReg <= !wFullNext && !bvalidNext;
      if (axiReq.wvalid && wreadyReg) begin
        wDataReg <= axiReq.wdata;
        wStrbReg <= axiReq.wstrb;
      end
    end
  end

  // The control register sits in byte lane 0 and steers the counter.
  always_comb begin
    ctrlNext = ctrlReg;
    if (doWrite && (awAddrReg == `PDC_OFS_CTRL) && wStrbReg[0]) begin
      ctrlNext = wordToCtrl(wDataReg);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrlReg <= `PDC_CTRL_RESET;
    end else begin
      ctrlReg <= ctrlNext;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      bvalidReg <= 1'b0;
      brespReg <= `PDC_RESP_OKAY;
    end else begin
      bvalidReg <= bvalidNext;
      if (doWrite) begin
        brespReg <= isMapped(awAddrReg) ? `PDC_RESP_OKAY : `PDC_RESP_SLVERR;
      end
    end
  end

  // The status word shows the counter's own state.
  always_comb begin
    statusWord = `PDC_WORD_ZERO;
    statusWord[`PDC_STAT_COUNT_MSB:`PDC_STAT_COUNT_LSB] = countReg;
    statusWord[`PDC_STAT_TC] = terminalCountReg;
    statusWord[`PDC_STAT_TRK] = trickleEff;
    statusWord[`PDC_STAT_CLR] = clearSeen;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      arFullReg <= 1'b0;
      arAddrReg <= `PDC_WORD_ZERO;
      arreadyReg <= 1'b0;
    end else begin
      arFullReg <= arFullNext;
      arreadyReg <= !arFullNext && !rvalidNext;
      if (axiReq.arvalid && arreadyReg) begin
        arAddrReg <= axiReq.araddr;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rvalidReg <= 1'b0;
      rdataReg <= `PDC_WORD_ZERO;
      rrespReg <= `PDC_RESP_OKAY;
    end else begin
      rvalidReg <= rvalidNext;
      if (doRead) begin
        case (arAddrReg)
          `PDC_OFS_CTRL: begin
            rdataReg <= ctrlToWord(ctrlReg);
            rrespReg <= `PDC_RESP_OKAY;
          end
          `PDC_OFS_STATUS: begin
            rdataReg <= statusWord;
            rrespReg <= `PDC_RESP_OKAY;
          end
          default: begin
            rdataReg <= `PDC_WORD_ZERO;
            rrespReg <= `PDC_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  assign axiRsp.awready = awreadyReg;
  assign axiRsp.wready = wreadyReg;
  assign axiRsp.bresp = brespReg;
  assign axiRsp.bvalid = bvalidReg;
  assign axiRsp.arready = arreadyReg;
  assign axiRsp.rdata = rdataReg;
  assign axiRsp.rresp = rrespReg;
  assign axiRsp.rvalid = rvalidReg;

  // Checks on the counter and the register slave.
  default clocking cb @(posedge core_clk);
  endclocking

  default disable iff (rst);

  sequence sCountStep;
    clearN && ctrlReg.loadEnableN && trickleEff && ctrlReg.countEnableParallel;
  endsequence

  sequence sStillClear;
    clearN ##1 (clearN && !clearHitReg);
  endsequence

  sequence sWriteTaken;
    axiReq.awvalid && awreadyReg && axiReq.wvalid && wreadyReg;
  endsequence

  sequence sReadTaken;
    axiReq.arvalid && arreadyReg;
  endsequence

  a_count_step: assert property (
    (sCountStep and (countReg < `PDC_COUNT_MAX)) ##0 sStillClear
      |-> countReg == $past(countReg) + `PDC_COUNT_ONE
  ) else $error("count did not advance by one");

  a_decade_wrap: assert property (
    (sCountStep and (countReg == `PDC_COUNT_MAX)) ##0 sStillClear
      |-> countReg == `PDC_COUNT_ZERO
  ) else $error("count did not wrap after nine");

  a_decade_range: assert property (
    (clearN && ctrlReg.loadEnableN && countReg <= `PDC_COUNT_MAX)
      |=> !clearN || countReg <= `PDC_COUNT_MAX
  ) else $error("count left the decade range");

  a_clear_zeroes: assert property (
    (!clearN || clearHitReg) |-> countReg == `PDC_COUNT_ZERO && !terminalCountReg
  ) else $error("clear did not zero the count");

  a_load_taken: assert property (
    (clearN && !ctrlReg.loadEnableN) ##0 sStillClear
      |-> countReg == $past(ctrlReg.loadValue)
  ) else $error("load value not taken");

  a_load_ignored: assert property (
    (clearN && ctrlReg.loadEnableN) |=> !clearN
      || countReg == $past(countReg) || countReg == incDecade($past(countReg))
  ) else $error("load value entered while load enable high");

  a_trickle_hold: assert property (
    (clearN && ctrlReg.loadEnableN && !trickleEff) |=> !clearN || $stable(countReg)
  ) else $error("count moved with trickle enable low");

  a_parallel_hold: assert property (
    (clearN && ctrlReg.loadEnableN && trickleEff && !ctrlReg.countEnableParallel)
      |=> !clearN || $stable(countReg)
  ) else $error("count moved with parallel enable low");

  a_terminal_match: assert property (
    terminalCountReg == ((countReg == `PDC_COUNT_MAX) && trickleEff)
  ) else $error("terminal count disagrees with the state");

  a_write_answer: assert property (
    sWriteTaken |=> ##1 bvalidReg
  ) else $error("write answer not on time");

  a_read_answer: assert property (
    sReadTaken |=> ##1 rvalidReg
  ) else $error("read answer not on time");

  a_resp_hold: assert property (
    (bvalidReg && !axiReq.bready) |=> bvalidReg && $stable(brespReg)
  ) else $error("write answer dropped early");

endmodule

`default_nettype wire

// ### src/pdc_params.svh
// Register offsets, field positions, reset values and count limits of the decade counter.
`ifndef PDC_PARAMS_SVH
`define PDC_PARAMS_SVH

`define PDC_OFS_CTRL 32'h0000_0000
`define PDC_OFS_STATUS 32'h0000_0004

`define PDC_CTRL_CEP 0
`define PDC_CTRL_CET 1
`define PDC_CTRL_LDN 2
`define PDC_CTRL_LOAD_LSB 4
`define PDC_CTRL_LOAD_MSB 7
`define PDC_CTRL_RESET 7'h04

`define PDC_STAT_COUNT_LSB 0
`define PDC_STAT_COUNT_MSB 3
`define PDC_STAT_TC 4
`define PDC_STAT_TRK 5
`define PDC_STAT_CLR 6

`define PDC_COUNT_ZERO 4'h0
`define PDC_COUNT_ONE 4'h1
`define PDC_COUNT_MAX 4'h9

`define PDC_RESP_OKAY 2'h0
`define PDC_RESP_SLVERR 2'h2

`define PDC_WORD_ZERO 32'h0000_0000

`endif

// ### src/pdc_pin_filter.sv
// Three-stage input filter for a pin from outside the clock domain.
`default_nettype none

module pdc_pin_filter (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic pinIn,
  output var logic level,
  output logic levelNext
);

  logic stage1Reg;
  logic stage2Reg;
  logic stage3Reg;

  // The level only moves once the second and third stages agree.
  assign levelNext = (stage2Reg == stage3Reg) ? stage3Reg : level;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      stage1Reg <= 1'b0;
      stage2Reg <= 1'b0;
      stage3Reg <= 1'b0;
    end else begin
      stage1Reg <= pinIn;
      stage2Reg <= stage1Reg;
      stage3Reg <= stage2Reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      level <= 1'b0;
    end else begin
      level <= levelNext;
    end
  end

endmodule

`default_nettype wire

// ### src/pdc_pkg.sv
// Types shared by the decade counter and its register bus.
`default_nettype none

package pdc_pkg;

  typedef struct packed {
    logic [3:0] loadValue;
    logic loadEnableN;
    logic countEnableTrickle;
    logic countEnableParallel;
  } pdc_ctrl_t;

  typedef struct packed {
    logic [31:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [31:0] araddr;
    logic arvalid;
    logic rready;
  } pdc_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } pdc_axi_rsp_t;

endpackage

`default_nettype wire

// ### test/pdc_drive_model.sv
// Model of the logic that drives the cascade enable pin and the clear pin.
`default_nettype none

module pdc_drive_model (
  input wire logic core_clk,
  input wire logic trickleLevel,
  input wire logic clearPulse,
  output var logic trickleIn,
  output var logic clearN
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    trickleIn = 1'b1;
    clearN = 1'b1;
  end
  // Enable changes land just after the rising edge, while the clock is high.
  always @(posedge core_clk) begin
    trickleIn <= trickleLevel;
  end
  // The clear pulse sits between rising edges, so its release never meets a rising edge.
  always @(posedge core_clk) begin
    if (clearPulse) begin
      #1 clearN = 1'b0;
      #3 clearN = 1'b1;
    end
  end
endmodule

`default_nettype wire

// ### test/presettable_decade_counter_tb.sv
// Self-checking bench for the decade counter, its register bus and its drive model.
`include "pdc_params.svh"
`default_nettype none

module presettable_decade_counter_tb import pdc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic trickleLevel = 1'b1;
  logic clearPulse = 1'b0;
  logic clearN;
  logic trickleIn;
  logic terminalCount;
  logic [3:0] countBits;
  pdc_axi_req_t axiReq = '0;
  pdc_axi_rsp_t axiRsp;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  logic [31:0] seed = 32'hC75E2AC4;
  logic [31:0] rd;
  logic [1:0] rsp;
  logic [3:0] v;
  logic [3:0] prev;

  pdc_drive_model partner (
    .core_clk(core_clk),
    .trickleLevel(trickleLevel),
    .clearPulse(clearPulse),
    .trickleIn(trickleIn),
    .clearN(clearN)
  );

  pdc_counter_top uut (
    .core_clk(core_clk),
    .rst(rst),
    .clearN(clearN),
    .trickleIn(trickleIn),
    .axiReq(axiReq),
    .axiRsp(axiRsp),
    .countBits(countBits),
    .terminalCount(terminalCount)
  );

  always #4 core_clk = ~core_clk;

  task automatic stop_test();
    $display("compares %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      $display("MISMATCH at %0t: timeout", $time);
      stop_test();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [3:0] step(input logic [3:0] c);
    return (c >= 4'h9) ? 4'h0 : c + 4'h1;
  endfunction

  function automatic logic [31:0] ctl(input logic [3:0] val, input logic ldn, count_enable_trickle, count_enable_parallel);
    return {24'h000000, val, 1'b0, ldn, count_enable_trickle, count_enable_parallel};
  endfunction

  task automatic check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    axiReq.awaddr <= a;
    axiReq.wdata <= d;
    axiReq.wstrb <= s;
    axiReq.awvalid <= 1'b1;
    axiReq.wvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (axiReq.awvalid && axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiReq.wvalid && axiRsp.wready) axiReq.wvalid <= 1'b0;
      if (!axiReq.awvalid && !axiReq.wvalid && !axiReq.bready) axiReq.bready <= 1'b1;
    end while (!(axiRsp.bvalid && axiReq.bready));
    rsp = axiRsp.bresp;
    axiReq.bready <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd_reg(input logic [31:0] a);
    axiReq.araddr <= a;
    axiReq.arvalid <= 1'b1;
    axiReq.rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (axiReq.arvalid && axiRsp.arready) axiReq.arvalid <= 1'b0;
    end while (!(axiRsp.rvalid && axiReq.rready));
    rd = axiRsp.rdata;
    rsp = axiRsp.rresp;
    axiReq.rready <= 1'b0;
    @(posedge core_clk);
  endtask

  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    check(countBits === 4'h0 && terminalCount === 1'b0, "reset count");
    rd_reg(`PDC_OFS_CTRL);
    check(rd === 32'h00000004 && rsp === `PDC_RESP_OKAY, "ctrl reset");
    $display("reset test done");
    for (int i = 0; i < 10; i++) begin
      v = (i < 2) ? 4'(9 * i) : 4'(rnd() % 10);
      wr(`PDC_OFS_CTRL, ctl(v, 1'b0, 1'b1, 1'(rnd())));
      wr(`PDC_OFS_CTRL, ctl(~v, 1'b1, 1'b0, 1'b0));
      repeat (3) @(posedge core_clk);
      check(countBits === v, "load value");
      check(terminalCount === 1'b0, "tc gated");
    end
    $display("load test done");
    wr(`PDC_OFS_CTRL, ctl(4'h7, 1'b0, 1'b1, 1'b1));
    wr(`PDC_OFS_CTRL, ctl(4'h0, 1'b1, 1'b1, 1'b1));
    @(posedge core_clk);
    prev = countBits;
    for (int i = 0; i < 25; i++) begin
      @(posedge core_clk);
      check(countBits === step(prev) && terminalCount === (step(prev) == 4'h9), "step");
      prev = countBits;
    end
    $display("count test done");
    for (int i = 0; i < 4; i++) begin
      trickleLevel <= (i != 3);
      wr(`PDC_OFS_CTRL, ctl(4'h9, 1'b0, 1'b0, 1'b0));
      wr(`PDC_OFS_CTRL, ctl(4'h9, 1'b1, 1'(i >> 1), 1'(i)));
      repeat (4) @(posedge core_clk);
      check(countBits === 4'h9 && terminalCount === (i == 2), "hold");
    end
    trickleLevel <= 1'b1;
    $display("hold test done");
    wr(`PDC_OFS_CTRL, ctl(4'h5, 1'b0, 1'b1, 1'b1));
    clearPulse <= 1'b1;
    @(posedge core_clk);
    clearPulse <= 1'b0;
    #2;
    check(countBits === 4'h0 && terminalCount === 1'b0, "clear");
    @(posedge core_clk);
    @(posedge core_clk);
    check(countBits === 4'h5, "load after clear");
    $display("clear test done");
    wr(32'h00000008, 32'h00000000);
    check(rsp === `PDC_RESP_SLVERR, "unmapped write");
    rd_reg(32'h00000010);
    check(rsp === `PDC_RESP_SLVERR && rd === 32'h00000000, "unmapped read");
    wr(`PDC_OFS_STATUS, 32'hFFFFFFFF);
    check(rsp === `PDC_RESP_OKAY, "status write");
    rd_reg(`PDC_OFS_STATUS);
    check(rd[6:0] === 7'h25 && rsp === `PDC_RESP_OKAY, "status read");
    wr(`PDC_OFS_CTRL, `PDC_WORD_ZERO, 4'hE);
    check(rsp === `PDC_RESP_OKAY, "masked ctrl write");
    rd_reg(`PDC_OFS_CTRL);
    check(rd === ctl(4'h5, 1'b0, 1'b1, 1'b1), "ctrl readback");
    $display("register test done");
    stop_test();
  end
endmodule

`default_nettype wire
